// file: esp_energy_sense.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE_01: Bit 15 enables sensing, resets to zero
// RULE_02: Software disables crossover when autonegotiation off
// RULE_03: Auto power-up when data count reaches threshold
// RULE_04: Auto power-down when line is silent
// RULE_05: Manual bit toggles power state immediately
// RULE_06: Burst disable clear: four pulses per power-up
// RULE_07: Burst disable set: one pulse per power-up
// RULE_08: Bit 10 shows current sense power state
// RULE_09: Error threshold flag, clear on read, informational
// RULE_10: Data threshold flag, clear on read
// RULE_11: Error threshold field bits 7:4, reset 0001
// RULE_12: Data threshold field bits 3:0, reset 0001
// RULE_13: Counters clear after two quiet seconds
// RULE_14: Manual toggle bit self-clears, reads zero
module esp_energy_sense import esp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int QUIET_LIMIT = QUIET_CYCLES,
  parameter int GAP_LIMIT = PULSE_GAP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic energy_data_event,
  input wire logic energy_error_event,
  input wire logic energy_present,
  output logic line_driver_power_up,
  output logic sense_pulse,
  output logic irq
);
  logic wr_valid, rd_valid;
  esp_wreq_t wr_req;
  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  esp_ctrl_t ctrl, next_ctrl;
  esp_state_t st, next_st;
  logic [3:0] data_cnt, err_cnt, next_data_cnt, next_err_cnt;
  logic data_hit, err_hit, next_data_hit, next_err_hit;
  logic [IRQ_W-1:0] irq_status, irq_mask, next_irq_status, next_irq_mask;
  logic [2:0] burst_left, next_burst_left;
  logic next_drv, next_pulse;
  logic wr_ctrl, man_req, rd_ctrl, rd_stat;
  logic go_up, go_down, toggle, cnt_clr, quiet_expire, gap_done, drv_rise;
  logic data_set, err_set;
  logic [15:0] ctrl_word;

  esp_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_valid(wr_valid),
    .wr_req(wr_req),
    .rd_valid(rd_valid),
    .rd_idx(rd_idx),
    .rd_data(rd_data)
  );

  // Restarted by every data event; expiry means the line stayed quiet
  esp_timer #(.W($clog2(QUIET_LIMIT + 1)), .LIMIT(QUIET_LIMIT)) u_quiet (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(energy_data_event || !ctrl.enable),
    .run(ctrl.enable),
    .expire(quiet_expire)
  );

  esp_timer #(.W($clog2(GAP_LIMIT + 1)), .LIMIT(GAP_LIMIT)) u_gap (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(drv_rise),
    .run(burst_left != 3'h0),
    .expire(gap_done)
  );

  always_comb
  begin
    wr_ctrl = wr_valid && (wr_req.idx == IDX_CTRL);
    man_req = wr_ctrl && wr_req.strb[1] && wr_req.data[BIT_MANUAL]; // see RULE_05
    rd_ctrl = rd_valid && (rd_idx == IDX_CTRL);
    rd_stat = rd_valid && (rd_idx == IDX_IRQ_STATUS);
    // Manual bit holds no state, so it always reads back zero
    ctrl_word = {ctrl.enable, ctrl.auto_up, ctrl.auto_down, 1'b0, // see RULE_14
                 ctrl.burst_dis, st == ST_UP, err_hit, data_hit, // see RULE_08
                 ctrl.err_thresh, ctrl.data_thresh};
    rd_data = 32'h0;
    case (rd_idx)
      IDX_CTRL: rd_data = {16'h0, ctrl_word};
      IDX_IRQ_STATUS: rd_data = {29'h0, irq_status};
      IDX_IRQ_MASK: rd_data = {29'h0, irq_mask};
      default: rd_data = 32'h0;
    endcase
    irq = |(irq_status & irq_mask);
  end

  always_comb
  begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    if (wr_ctrl && wr_req.strb[1])
    begin
      next_ctrl.enable = wr_req.data[BIT_ENABLE]; // see RULE_01
      next_ctrl.auto_up = wr_req.data[BIT_AUTO_UP];
      next_ctrl.auto_down = wr_req.data[BIT_AUTO_DOWN];
      next_ctrl.burst_dis = wr_req.data[BIT_BURST_DIS];
    end
    if (wr_ctrl && wr_req.strb[0])
    begin
      next_ctrl.err_thresh = wr_req.data[ERR_LSB +: THRESH_W]; // see RULE_11
      next_ctrl.data_thresh = wr_req.data[DATA_LSB +: THRESH_W]; // see RULE_12
    end
    if (wr_valid && (wr_req.idx == IDX_IRQ_MASK) && wr_req.strb[0])
      next_irq_mask = wr_req.data[IRQ_W-1:0];
  end

  always_comb
  begin
    go_up = (st == ST_DOWN) && ctrl.auto_up && (data_cnt >= ctrl.data_thresh); // see RULE_03
    go_down = (st == ST_UP) && ctrl.auto_down && !energy_present; // see RULE_04
    // Manual request ignores counters and timers
    toggle = ctrl.enable && (man_req || go_up || go_down); // see RULE_05
    next_st = st;
    if (!ctrl.enable)
      next_st = ST_DOWN; // see RULE_01
    else if (toggle)
    begin
      case (st)
        ST_DOWN: next_st = ST_UP;
        ST_UP: next_st = ST_DOWN;
        default: next_st = ST_DOWN;
      endcase
    end
  end

  always_comb
  begin
    cnt_clr = !ctrl.enable || quiet_expire || toggle; // see RULE_13
    data_set = ctrl.enable && energy_data_event && (sat_inc(data_cnt) >= ctrl.data_thresh);
    // Error threshold only raises a flag; it never moves the power state
    err_set = ctrl.enable && energy_error_event && (sat_inc(err_cnt) >= ctrl.err_thresh); // see RULE_09
    next_data_cnt = data_cnt;
    next_err_cnt = err_cnt;
    if (cnt_clr)
    begin
      next_data_cnt = 4'h0;
      next_err_cnt = 4'h0;
    end
    else
    begin
      if (energy_data_event)
        next_data_cnt = sat_inc(data_cnt);
      if (energy_error_event)
        next_err_cnt = sat_inc(err_cnt);
    end
    // A set in the same cycle as the clearing read wins
    next_data_hit = data_set || (data_hit && !rd_ctrl); // see RULE_10
    next_err_hit = err_set || (err_hit && !rd_ctrl); // see RULE_09
    next_irq_status = irq_status & ~{IRQ_W{rd_stat}};
    next_irq_status[IRQ_DATA] = data_set || next_irq_status[IRQ_DATA];
    next_irq_status[IRQ_ERR] = err_set || next_irq_status[IRQ_ERR];
    next_irq_status[IRQ_PWR] = (next_st != st) || next_irq_status[IRQ_PWR];
  end

  always_comb
  begin
    // With sensing off the driver simply stays powered
    next_drv = !ctrl.enable || (st == ST_UP);
    drv_rise = next_drv && !line_driver_power_up;
    next_burst_left = burst_left;
    if (drv_rise)
      next_burst_left = ctrl.burst_dis ? BURST_SHORT : BURST_LONG; // see RULE_06, RULE_07
    else if (gap_done)
      next_burst_left = burst_left - 3'h1;
    next_pulse = gap_done;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= '{enable: RST_ENABLE, auto_up: RST_AUTO_UP, auto_down: RST_AUTO_DOWN,
                burst_dis: RST_BURST_DIS, err_thresh: RST_THRESH, data_thresh: RST_THRESH};
      irq_mask <= '0;
      st <= ST_DOWN;
      data_cnt <= 4'h0;
      err_cnt <= 4'h0;
      data_hit <= 1'b0;
      err_hit <= 1'b0;
      irq_status <= '0;
      burst_left <= 3'h0;
      line_driver_power_up <= 1'b1;
      sense_pulse <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      irq_mask <= next_irq_mask;
      st <= next_st;
      data_cnt <= next_data_cnt;
      err_cnt <= next_err_cnt;
      data_hit <= next_data_hit;
      err_hit <= next_err_hit;
      irq_status <= next_irq_status;
      burst_left <= next_burst_left;
      line_driver_power_up <= next_drv;
      sense_pulse <= next_pulse;
    end
  end

  logic [2:0] pulses_since_up;
  logic burst_one_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulses_since_up <= 3'h0;
      burst_one_q <= 1'b0;
    end
    else if (drv_rise)
    begin
      pulses_since_up <= 3'h0;
      burst_one_q <= ctrl.burst_dis;
    end
    else if (sense_pulse && pulses_since_up != 3'h7)
      pulses_since_up <= pulses_since_up + 3'h1;
  end

  AST_DISABLED_DRIVER: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_01
    !ctrl.enable |=> line_driver_power_up && st == ST_DOWN)
    else $error("driver not powered while sensing disabled");
  AST_AUTO_UP: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_03
    (ctrl.enable && st == ST_DOWN && ctrl.auto_up && data_cnt >= ctrl.data_thresh)
    |=> st == ST_UP ##1 line_driver_power_up)
    else $error("no automatic power-up at data threshold");
  AST_AUTO_DOWN: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_04
    (ctrl.enable && st == ST_UP && ctrl.auto_down && !energy_present && !man_req)
    |=> st == ST_DOWN)
    else $error("no automatic power-down on silence");
  AST_MANUAL_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_05
    (ctrl.enable && man_req) |=> st != $past(st))
    else $error("manual toggle did not change state");
  AST_BURST_FOUR: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_06
    !burst_one_q |-> pulses_since_up <= 3'h4)
    else $error("more than four pulses after power-up");
  AST_BURST_ONE: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
    (drv_rise && ctrl.burst_dis) |=> burst_left == 3'h1 && pulses_since_up == 3'h0)
    else $error("single pulse burst not loaded");
  AST_STATE_BIT: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_08
    rd_ctrl |=> s_axi_rdata[BIT_PWR_STATE] == ($past(st) == ST_UP))
    else $error("power state bit mismatch");
  AST_ERR_COR: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_09
    (rd_ctrl && !err_set) |=> !err_hit)
    else $error("error flag not cleared by read");
  AST_DATA_HIT: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_10
    (ctrl.enable && energy_data_event && sat_inc(data_cnt) >= ctrl.data_thresh)
    |=> data_hit)
    else $error("data threshold flag not set");
  AST_THRESH_RESET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_11
    $rose(aresetn) |-> ctrl.err_thresh == 4'h1 && ctrl.data_thresh == 4'h1 && !ctrl.enable)
    else $error("threshold reset values wrong");
  AST_QUIET_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_13
    quiet_expire |=> data_cnt == 4'h0 && err_cnt == 4'h0)
    else $error("counters not cleared after quiet time");
  AST_MANUAL_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_14
    man_req |=> ##1 !(s_axi_rvalid && $past(rd_ctrl) && s_axi_rdata[BIT_MANUAL]))
    else $error("manual bit read back as one");
endmodule : esp_energy_sense
`default_nettype wire

// file: esp_pkg.sv
`default_nettype none
package esp_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int QUIET_TIME_MS = 2000;
  localparam int QUIET_CYCLES = QUIET_TIME_MS * (CLK_HZ / 1000);
  localparam int PULSE_GAP_NS = 1000;
  localparam int PULSE_GAP_CYCLES = (PULSE_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [5:0] IDX_CTRL = 6'h1d;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h1e;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h1f;

  localparam int BIT_ENABLE = 15;
  localparam int BIT_AUTO_UP = 14;
  localparam int BIT_AUTO_DOWN = 13;
  localparam int BIT_MANUAL = 12;
  localparam int BIT_BURST_DIS = 11;
  localparam int BIT_PWR_STATE = 10;
  localparam int BIT_ERR_HIT = 9;
  localparam int BIT_DATA_HIT = 8;
  localparam int ERR_LSB = 4;
  localparam int DATA_LSB = 0;
  localparam int THRESH_W = 4;

  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_AUTO_UP = 1'b1;
  localparam logic RST_AUTO_DOWN = 1'b1;
  localparam logic RST_BURST_DIS = 1'b0;
  localparam logic [3:0] RST_THRESH = 4'h1;

  localparam logic [2:0] BURST_LONG = 3'h4;
  localparam logic [2:0] BURST_SHORT = 3'h1;

  localparam int IRQ_W = 3;
  localparam int IRQ_DATA = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_PWR = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic auto_up;
    logic auto_down;
    logic burst_dis;
    logic [3:0] err_thresh;
    logic [3:0] data_thresh;
  } esp_ctrl_t;

  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } esp_wreq_t;

  typedef enum logic [1:0] {
    ST_DOWN = 2'b01,
    ST_UP = 2'b10
  } esp_state_t;

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == 4'hf) ? v : v + 4'h1;
  endfunction : sat_inc

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == IDX_CTRL) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
  endfunction : is_mapped
endpackage : esp_pkg
`default_nettype wire

// file: esp_timer.sv
`timescale 1ns/1ns
`default_nettype none
module esp_timer #(
  parameter int W = 8,
  parameter int LIMIT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic run,
  output logic expire
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Clear beats expiry so a restart never fires in the cycle that clears it
  always_comb
  begin
    expire = run && !clear && (count == W'(LIMIT - 1));
    next_count = count;
    if (clear || !run || expire)
      next_count = '0;
    else
      next_count = count + W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else
      count <= next_count;
  end
endmodule : esp_timer
`default_nettype wire

// file: esp_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module esp_axil_slave import esp_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_valid,
  output esp_wreq_t wr_req,
  output logic rd_valid,
  output logic [5:0] rd_idx,
  input wire logic [31:0] rd_data
);
  logic aw_full, w_full;
  logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic [5:0] aw_idx, next_aw_idx;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;

  always_comb
  begin
    awready = !aw_full;
    wready = !w_full;
    // One write at a time: a new one waits until the response is taken
    wr_valid = aw_full && w_full && !bvalid;
    wr_req = '{idx: aw_idx, data: w_data, strb: w_strb};
    arready = !rvalid;
    rd_valid = arvalid && arready;
    rd_idx = 6'(araddr[ADDR_W-1:2]);
    next_aw_full = aw_full;
    next_aw_idx = aw_idx;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready)
    begin
      next_aw_full = 1'b1;
      next_aw_idx = 6'(awaddr[ADDR_W-1:2]);
    end
    if (wvalid && wready)
    begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_valid)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_valid)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_idx <= 6'h0;
      w_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      aw_idx <= next_aw_idx;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule : esp_axil_slave
`default_nettype wire

// file: esp_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// file: esp_line_model.sv
`timescale 1ns/1ns
`default_nettype none
module esp_line_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [3:0] n_data,
  input wire logic [3:0] n_err,
  input wire logic slow,
  input wire logic present_cmd,
  input wire logic line_driver_power_up,
  input wire logic sense_pulse,
  output logic energy_data_event,
  output logic energy_error_event,
  output logic energy_present,
  output logic busy,
  output logic [3:0] pulses
);
  logic [3:0] data_left;
  logic [3:0] err_left;
  logic phase;
  logic drv_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_left <= 4'h0;
      err_left <= 4'h0;
      phase <= 1'b0;
      // Driver resets powered, so a low start would fake a rise
      drv_q <= 1'b1;
      busy <= 1'b0;
      pulses <= 4'h0;
      energy_data_event <= 1'b0;
      energy_error_event <= 1'b0;
      energy_present <= 1'b0;
    end
    else
    begin
      energy_present <= present_cmd;
      drv_q <= line_driver_power_up;
      // Burst starts after the rise, so the restart never meets a pulse
      if (line_driver_power_up && !drv_q)
        pulses <= 4'h0;
      else if (sense_pulse)
        pulses <= pulses + 4'h1;
      // Slow mode leaves a quiet cycle between events
      phase <= slow ? ~phase : 1'b0;
      energy_data_event <= 1'b0;
      energy_error_event <= 1'b0;
      if (go)
      begin
        data_left <= n_data;
        err_left <= n_err;
        busy <= (n_data != 4'h0) || (n_err != 4'h0);
      end
      else if (!phase)
      begin
        if (data_left != 4'h0)
        begin
          energy_data_event <= 1'b1;
          data_left <= data_left - 4'h1;
        end
        if (err_left != 4'h0)
        begin
          energy_error_event <= 1'b1;
          err_left <= err_left - 4'h1;
        end
        busy <= (data_left > 4'h1) || (err_left > 4'h1);
      end
    end
  end
endmodule : esp_line_model
`default_nettype wire

// file: energy_detect_power_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module energy_detect_power_control_test import esp_pkg::*;;
  localparam int QL = 64;
  localparam int GL = 4;
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, go, slow, present, busy, irq;
  logic ded, eed, epr, line_driver_power_up, sense_pulse;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, n_data, n_err, pulses;
  logic [1:0] bresp, rresp;
  int failures, total_checks, seed;
  esp_energy_sense #(.ADDR_W(8), .QUIET_LIMIT(QL), .GAP_LIMIT(GL)) uut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .energy_data_event(ded), .energy_error_event(eed), .energy_present(epr),
    .line_driver_power_up(line_driver_power_up), .sense_pulse(sense_pulse), .irq(irq));
  esp_line_model line (.aclk(aclk), .aresetn(aresetn), .go(go), .n_data(n_data),
    .n_err(n_err), .slow(slow), .present_cmd(present),
    .line_driver_power_up(line_driver_power_up), .sense_pulse(sense_pulse),
    .energy_data_event(ded), .energy_error_event(eed), .energy_present(epr),
    .busy(busy), .pulses(pulses));
  function automatic logic [31:0] cw(input logic en, up, dn, bd, pw, eh, dh,
    input logic [3:0] e, input logic [3:0] d);
    cw = {16'h0, en, up, dn, 1'b0, bd, pw, eh, dh, e, d};
  endfunction : cw
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic hang;
    failures++;
    end_sim();
  endtask : hang
  // bready and rready stay high, so only the valids ever move
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50 && !got; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        got = 1'b1;
      end
    end
    if (!got) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic got;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50 && !got; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        got = 1'b1;
      end
    end
    if (!got) hang();
  endtask : axi_rd
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, RESP_OKAY);
  endtask : wr_ok
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(a, d, r);
    check(r, RESP_OKAY);
    check(d, exp);
  endtask : rd_chk
  task automatic send(input logic [3:0] nd, input logic [3:0] ne, input logic sl);
    int n;
    n_data <= nd;
    n_err <= ne;
    slow <= sl;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    for (n = 0; n < 100 && busy; n++) @(posedge aclk);
    if (busy) hang();
    repeat (3) @(posedge aclk);
  endtask : send
  task automatic wait_drv(input logic v);
    int n;
    for (n = 0; n < 20 && line_driver_power_up !== v; n++) @(posedge aclk);
    check(line_driver_power_up, v);
  endtask : wait_drv
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic [3:0] th, er;
    logic sl;
    {awvalid, wvalid, arvalid, go, slow, present} = 6'h0;
    {awaddr, araddr, wdata, n_data, n_err} = '0;
    {bready, rready, wstrb} = 6'h3f;
    aresetn = 1'b0;
    failures = 0;
    total_checks = 0;
    seed = 61;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check(line_driver_power_up, 1'b1);
    rd_chk(A_CTRL, cw(0, 1, 1, 0, 0, 0, 0, 4'h1, 4'h1));
    rd_chk(A_MASK, 32'h0);
    axi_rd(8'h40, d, r);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
    axi_wr(8'h40, 32'hffff, r);
    check(r, RESP_SLVERR);
    $display("test reset_map done");
    th = 4'h2 + 4'($unsigned($random(seed)) % 4);
    er = 4'h1 + 4'($unsigned($random(seed)) % 3);
    sl = 1'($random(seed));
    present <= 1'b1;
    wr_ok(A_CTRL, cw(1, 1, 1, 0, 0, 0, 0, er, th)); // Crossover lives outside
    wait_drv(1'b0);
    send(th - 4'h1, 4'h0, sl);
    repeat (QL + 8) @(posedge aclk);
    send(th - 4'h1, 4'h0, sl);
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 0, 0, 0, er, th));
    send(4'h1, 4'h0, sl);
    wait_drv(1'b1);
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 1, 0, 1, er, th));
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 1, 0, 0, er, th));
    repeat (8 * GL) @(posedge aclk);
    check(pulses, 4'h4);
    $display("test auto_up done");
    send(4'h0, er, 1'b0);
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 1, 1, 0, er, th));
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 1, 0, 0, er, th));
    present <= 1'b0;
    wait_drv(1'b0);
    rd_chk(A_CTRL, cw(1, 1, 1, 0, 0, 0, 0, er, th));
    present <= 1'b1;
    $display("test error_down done");
    wr_ok(A_CTRL, cw(1, 1, 1, 1, 0, 0, 0, er, th) | 32'h1000);
    wait_drv(1'b1);
    rd_chk(A_CTRL, cw(1, 1, 1, 1, 1, 0, 0, er, th));
    repeat (8 * GL) @(posedge aclk);
    check(pulses, 4'h1);
    // Auto-down off, then both auto modes off: silence and data events must leave the state alone
    wr_ok(A_CTRL, cw(1, 1, 0, 1, 0, 0, 0, er, th));
    present <= 1'b0;
    repeat (4) @(posedge aclk);
    check(line_driver_power_up, 1'b1);
    wr_ok(A_CTRL, cw(1, 0, 0, 1, 0, 0, 0, er, 4'h1) | 32'h1000);
    rd_chk(A_CTRL, cw(1, 0, 0, 1, 0, 0, 0, er, 4'h1));
    send(4'h2, 4'h0, 1'b0);
    check(line_driver_power_up, 1'b0);
    rd_chk(A_CTRL, cw(1, 0, 0, 1, 0, 0, 1, er, 4'h1));
    $display("test manual done");
    wr_ok(A_CTRL, cw(0, 1, 1, 0, 0, 0, 0, 4'h1, 4'h1));
    wait_drv(1'b1);
    send(4'h3, 4'h3, 1'b0);
    rd_chk(A_CTRL, cw(0, 1, 1, 0, 0, 0, 0, 4'h1, 4'h1));
    repeat (8 * GL) @(posedge aclk);
    check(pulses, 4'h4);
    $display("test disable done");
    // Events above left every status bit set while masked
    check(irq, 1'b0);
    wr_ok(A_MASK, 32'h7);
    rd_chk(A_MASK, 32'h7);
    check(irq, 1'b1);
    rd_chk(A_STAT, 32'h7);
    check(irq, 1'b0);
    rd_chk(A_STAT, 32'h0);
    $display("test irq done");
    end_sim();
  end
endmodule : energy_detect_power_control_test
`default_nettype wire
